// >>> core/adcrb_consts.vh
// Constants for the converter reference and result-buffer control block.
`ifndef ADCRB_CONSTS_VH
`define ADCRB_CONSTS_VH
// Register index on the plain port.
`define ADCRB_CTRL_ADDR 4'h0
`define ADCRB_STAT_ADDR 4'h1
`define ADCRB_ADDR_W 4
// Field positions of the control register.
`define ADCRB_POS_REF_HI 15
`define ADCRB_POS_REF_LO 14
`define ADCRB_NEG_REF 13
`define ADCRB_OFFSET_CAL_MODE_BIT 12
`define ADCRB_CHIDX_BIT 11
`define ADCRB_SCAN_BIT 10
`define ADCRB_HALF_BIT 7
`define ADCRB_RATE_HI 6
`define ADCRB_RATE_LO 2
`define ADCRB_SPLIT_BIT 1
`define ADCRB_ALT_BIT 0
// Writable bits: 15..10 and 6..0; 9..8 unimplemented, 7 read-only.
`define ADCRB_WR_MASK 16'hfc7f
`define ADCRB_RESET 16'h0000
// Reference source codes.
`define ADCRB_REF_ANALOG_SUPPLY 2'h0
`define ADCRB_REF_EXT 2'h1
`define ADCRB_REF_BG2 2'h2
`define ADCRB_REF_BG4 2'h3
`endif

// >>> core/adcrb_scan.v
// Input scan and alternate-sample channel sequencer.
`timescale 1ns/1ps
module adcrb_scan #(
  parameter CH_W = 4
)
(
  // Clock and reset
  input wire clk_sys,
  input wire rst_n,
  input wire ce,
  // Control
  input wire scan_en,
  input wire alt_en,
  input wire [15:0] scan_mask,
  input wire [CH_W-1:0] sel_a,
  input wire [CH_W-1:0] sel_b,
  input wire step,
  input wire restart,
  // Result
  output reg [CH_W-1:0] chan_q,
  output reg use_b_q
);

  reg [CH_W-1:0] scan_ptr_q;
  reg [CH_W-1:0] nxt;
  integer i;
  reg found;

  // Find the next enabled scan input after the current pointer.
  always @*
  begin
    nxt = scan_ptr_q;
    found = 1'b0;
    for (i = 1; i <= 16; i = i + 1)
    begin
      if (!found && scan_mask[(scan_ptr_q + i[CH_W-1:0]) & {CH_W{1'b1}}])
      begin
        nxt = scan_ptr_q + i[CH_W-1:0];
        found = 1'b1;
      end
    end
  end

  // Sequencer state; alternation flips A and B on each sample.
  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      scan_ptr_q <= {CH_W{1'b0}};
      chan_q <= {CH_W{1'b0}};
      use_b_q <= 1'b0;
    end
    else if (ce)
    begin
      if (restart)
      begin
        scan_ptr_q <= {CH_W{1'b0}};
        use_b_q <= 1'b0;
        chan_q <= scan_en ? {CH_W{1'b0}} : sel_a;
      end
      else if (step)
      begin
        if (alt_en)
          use_b_q <= ~use_b_q; // [RULE8]
        else
          use_b_q <= 1'b0; // [RULE8]
        if (scan_en)
        begin
          scan_ptr_q <= nxt; // [RULE3]
          chan_q <= (alt_en && !use_b_q) ? sel_b : nxt; // [RULE3]
        end
        else
          chan_q <= (alt_en && !use_b_q) ? sel_b : sel_a; // [RULE3]
      end
      // Clearing the alternate bit drops a pending B select at once, not at the next sample.
      else if (!alt_en)
        use_b_q <= 1'b0; // [RULE8]
    end
  end

endmodule

// >>> core/adcrb_fill.v
// Result buffer write-address and interrupt-rate logic.
`timescale 1ns/1ps
module adcrb_fill #(
  parameter AW = 5
)
(
  // Clock and reset
  input wire clk_sys,
  input wire rst_n,
  input wire ce,
  // Control
  input wire chan_idx_en,
  input wire split_en,
  input wire [4:0] rate,
  input wire restart,
  // Conversion completion
  input wire done,
  input wire [3:0] done_chan,
  // Result
  output reg [AW-1:0] addr_q,
  output reg wr_q,
  output reg half_q,
  output reg irq_q
);

  reg [4:0] cnt_q;
  reg [AW-1:0] fifo_q;
  wire last = (cnt_q == rate);
  wire [AW-1:0] base = (split_en && half_q) ? {1'b1, {(AW-1){1'b0}}} : {AW{1'b0}};

  // Count conversions; interrupt after rate+1 of them.
  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_q <= 5'h00;
      fifo_q <= {AW{1'b0}};
      addr_q <= {AW{1'b0}};
      wr_q <= 1'b0;
      half_q <= 1'b0;
      irq_q <= 1'b0;
    end
    else if (ce)
    begin
      wr_q <= done;
      irq_q <= done && last; // [RULE5]
      if (restart)
      begin
        cnt_q <= 5'h00;
        fifo_q <= {AW{1'b0}};
        half_q <= 1'b0;
      end
      else if (done)
      begin
        // Channel-indexed placement ignores the fill pointer entirely.
        if (chan_idx_en)
          addr_q <= {{(AW-4){1'b0}}, done_chan}; // [RULE9]
        else
          addr_q <= base | fifo_q; // [RULE6]
        if (last)
        begin
          cnt_q <= 5'h00;
          fifo_q <= {AW{1'b0}}; // [RULE6]
          if (split_en && !chan_idx_en)
            half_q <= ~half_q; // [RULE4] [RULE7]
          else
            half_q <= 1'b0; // [RULE7]
        end
        else
        begin
          cnt_q <= cnt_q + 5'h01;
          fifo_q <= fifo_q + {{(AW-1){1'b0}}, 1'b1};
        end
      end
    end
  end

endmodule

// >>> core/adcrb_top.v
// Converter reference, scan and result-buffer control register block.
// ----------------------------------------------------------------
// Notes on behaviour
// [RULE1] Positive reference: 11 four bandgap, 10 twice bandgap, 01 external, 00 supply.
// [RULE2] Negative reference: set selects external pin, clear selects analog ground.
// [RULE3] Scan enable steps multiplexer A through selected inputs; clear means no scanning. The code also steps the pointer on B samples, skipping inputs.
// [RULE4] Read-only status shows which buffer half is being filled.
// [RULE5] Five-bit field sets conversions completed per interrupt.
// [RULE6] Split mode alternates halves per interrupt; else restart at first location.
// [RULE7] Split mode and half status act only in FIFO mode.
// [RULE8] Alternate bit uses A then B selects; clear always uses A.
// [RULE9] Channel-indexed mode writes each result at its channel's slot.
// ----------------------------------------------------------------
`timescale 1ns/1ps
`include "adcrb_consts.vh"
module adcrb_top #(
  parameter AW = 5
)
(
  // Clock, enable and reset
  input wire clk_sys,
  input wire rst_n,
  input wire ce,
  // Register port
  input wire [`ADCRB_ADDR_W-1:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [15:0] reg_rdata_q,
  // Converter side
  input wire conv_done,
  input wire [3:0] conv_chan,
  input wire [15:0] scan_mask,
  input wire [3:0] sel_a,
  input wire [3:0] sel_b,
  input wire restart,
  // Analog routing and buffer controls
  output reg [3:0] pos_ref_onehot_q,
  output reg neg_ref_ext_q,
  output reg offset_cal_mode_q,
  output reg [3:0] mux_chan_q,
  output reg mux_use_b_q,
  output reg [AW-1:0] buf_addr_q,
  output reg buf_wr_q,
  output reg irq_q
);

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  reg [15:0] ctrl_q;
  wire [1:0] pos_ref_select = ctrl_q[`ADCRB_POS_REF_HI:`ADCRB_POS_REF_LO];
  wire neg_ref_select = ctrl_q[`ADCRB_NEG_REF];
  wire channel_indexed_buffer_en = ctrl_q[`ADCRB_CHIDX_BIT];
  wire input_scan_en = ctrl_q[`ADCRB_SCAN_BIT];
  wire [4:0] conversions_per_irq = ctrl_q[`ADCRB_RATE_HI:`ADCRB_RATE_LO];
  wire split_buffer_mode = ctrl_q[`ADCRB_SPLIT_BIT];
  wire alternate_input_sample = ctrl_q[`ADCRB_ALT_BIT];
  wire half_fill_status;
  wire [3:0] chan;
  wire use_b;
  wire [AW-1:0] addr;
  wire wr;
  wire irq;

  // Decode a reference code to a one-hot switch select.
  function [3:0] adcrb_ref_dec;
    input [1:0] code;
    begin
      case (code)
        `ADCRB_REF_BG4: adcrb_ref_dec = 4'h8;
        `ADCRB_REF_BG2: adcrb_ref_dec = 4'h4;
        `ADCRB_REF_EXT: adcrb_ref_dec = 4'h2;
        default: adcrb_ref_dec = 4'h1;
      endcase
    end
  endfunction

  // Software writes only the writable bits; bit 7 always shows live status.
  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      ctrl_q <= `ADCRB_RESET;
    else if (ce && reg_wr && reg_addr == `ADCRB_CTRL_ADDR)
      ctrl_q <= reg_wdata & `ADCRB_WR_MASK;
  end

  // Read data stands in the cycle after the strobe only; unmapped reads zero.
  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      reg_rdata_q <= 16'h0000;
    else if (ce)
    begin
      if (reg_rd && reg_addr == `ADCRB_CTRL_ADDR)
        reg_rdata_q <= (ctrl_q & `ADCRB_WR_MASK) | {8'h00, half_fill_status, 7'h00}; // [RULE4]
      else if (reg_rd && reg_addr == `ADCRB_STAT_ADDR)
        reg_rdata_q <= {6'h00, mux_use_b_q, mux_chan_q, buf_addr_q};
      else
        reg_rdata_q <= 16'h0000;
    end
  end

  // ----------------------------------------------------------------
  // Reference routing
  // ----------------------------------------------------------------
  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pos_ref_onehot_q <= 4'h1;
      neg_ref_ext_q <= 1'b0;
      offset_cal_mode_q <= 1'b0;
    end
    else if (ce)
    begin
      pos_ref_onehot_q <= adcrb_ref_dec(pos_ref_select); // [RULE1]
      neg_ref_ext_q <= neg_ref_select; // [RULE2]
      offset_cal_mode_q <= ctrl_q[`ADCRB_OFFSET_CAL_MODE_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Sequencer and buffer fill
  // ----------------------------------------------------------------
  adcrb_scan #(
    .CH_W(4)
  ) u_scan (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .ce(ce),
    .scan_en(input_scan_en),
    .alt_en(alternate_input_sample),
    .scan_mask(scan_mask),
    .sel_a(sel_a),
    .sel_b(sel_b),
    .step(conv_done),
    .restart(restart),
    .chan_q(chan),
    .use_b_q(use_b)
  );

  // Split mode only counts in FIFO layout; the gating keeps stale halves out.
  adcrb_fill #(
    .AW(AW)
  ) u_fill (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .ce(ce),
    .chan_idx_en(channel_indexed_buffer_en),
    .split_en(split_buffer_mode & ~channel_indexed_buffer_en), // [RULE7]
    .rate(conversions_per_irq),
    .restart(restart),
    .done(conv_done),
    .done_chan(conv_chan),
    .addr_q(addr),
    .wr_q(wr),
    .half_q(half_fill_status),
    .irq_q(irq)
  );

  // Outputs re-registered so each comes straight from a flip-flop.
  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mux_chan_q <= 4'h0;
      mux_use_b_q <= 1'b0;
      buf_addr_q <= {AW{1'b0}};
      buf_wr_q <= 1'b0;
      irq_q <= 1'b0;
    end
    else if (ce)
    begin
      mux_chan_q <= chan;
      mux_use_b_q <= use_b;
      buf_addr_q <= addr;
      buf_wr_q <= wr;
      irq_q <= irq;
    end
  end

endmodule

// >>> testbench/adcrb_properties.sv
// Port checks for the converter reference and result-buffer control block.
`timescale 1ns/1ps
module adcrb_properties #(
  parameter AW = 5
)
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic ce,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata_q,
  // Converter side
  input wire logic conv_done,
  input wire logic [3:0] conv_chan,
  input wire logic [3:0] pos_ref_onehot_q,
  input wire logic neg_ref_ext_q,
  input wire logic mux_use_b_q,
  input wire logic [AW-1:0] buf_addr_q,
  input wire logic buf_wr_q,
  input wire logic irq_q
);
  // ----------------------------------------
  // Control shadow and properties
  // ----------------------------------------
  wire wr_ctrl = ce && reg_wr && reg_addr == 4'h0;
  reg [15:0] ctrl_q;

  // Shadow copy lets mode-dependent checks know what software last set.
  always @(posedge clk_sys or negedge rst_n)
    if (!rst_n)
      ctrl_q <= 16'h0000;
    else if (wr_ctrl)
      ctrl_q <= reg_wdata;

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  a_pos_ref_decode: assert property (wr_ctrl |-> ##2
    pos_ref_onehot_q == 4'h1 << $past(reg_wdata[15:14], 2)) else $error("bad pos ref");
  a_ref_one_hot: assert property ($onehot(pos_ref_onehot_q)) else $error("ref not one-hot");
  a_neg_ref_route: assert property (wr_ctrl |-> ##2
    neg_ref_ext_q == $past(reg_wdata[13], 2)) else $error("bad neg ref");
  a_read_window: assert property (!$past(reg_rd) |-> reg_rdata_q == 16'h0000)
    else $error("read data outside window");
  a_irq_with_write: assert property (irq_q |-> buf_wr_q) else $error("irq without write");
  a_write_follows: assert property (ce && conv_done |-> ##2 buf_wr_q)
    else $error("no buffer write");
  a_fifo_restart: assert property (ce && conv_done && ctrl_q[11:0] == 12'h000
    |-> ##2 buf_addr_q == 0) else $error("fifo did not restart");
  a_chan_slot: assert property (ce && conv_done && ctrl_q[11]
    |-> ##2 buf_addr_q[3:0] == $past(conv_chan, 2)) else $error("wrong channel slot");
  a_alt_off_a: assert property ((!ctrl_q[0])[*3] |-> !mux_use_b_q)
    else $error("B select without alternate");
endmodule

// >>> testbench/adcrb_top_tb.sv
// Self-checking bench for the reference and result-buffer control block.
`timescale 1ns/1ps
`include "adcrb_consts.vh"
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin err_total++; \
  $display("ERROR %0t: got %h want %h", $time, g, e); end end
module adcrb_top_tb;
  reg clk_sys = 1'b0;
  reg rst_n = 1'b0;
  reg ce = 1'b1;
  reg reg_wr = 1'b0, reg_rd = 1'b0, conv_done = 1'b0, restart = 1'b0;
  reg [3:0] reg_addr = 4'h0, conv_chan = 4'h0;
  reg [15:0] reg_wdata = 16'h0000;
  wire [15:0] reg_rdata_q;
  wire [3:0] pos_ref_onehot_q, mux_chan_q;
  wire neg_ref_ext_q, offset_cal_mode_q, mux_use_b_q, buf_wr_q, irq_q;
  wire [4:0] buf_addr_q;
  integer err_total = 0, check_count = 0, k;

  adcrb_top #(.AW(5)) i_dut (.clk_sys, .rst_n, .ce, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata_q, .conv_done, .conv_chan, .scan_mask(16'hffff), .sel_a(4'h5),
    .sel_b(4'ha), .restart, .pos_ref_onehot_q, .neg_ref_ext_q, .offset_cal_mode_q,
    .mux_chan_q, .mux_use_b_q, .buf_addr_q, .buf_wr_q, .irq_q);

  // ----------------------------------------
  // Access tasks
  // ----------------------------------------
  // Returns once the registered reference outputs have caught up.
  task wr(input [3:0] a, input [15:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    @(posedge clk_sys);
    #1;
  endtask

  // Read data is only valid in the cycle after the strobe.
  task rd(input [3:0] a, input [15:0] e);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    `CHK(reg_rdata_q, e)
  endtask

  // One completed conversion; the write shows two cycles later.
  task conv(input [3:0] ch, input [4:0] ea, input ei);
    @(posedge clk_sys);
    conv_done <= 1'b1;
    conv_chan <= ch;
    @(posedge clk_sys);
    conv_done <= 1'b0;
    @(posedge clk_sys);
    #1;
    `CHK(buf_wr_q, 1'b1)
    `CHK(buf_addr_q, ea)
    `CHK(irq_q, ei)
  endtask

  // Restart after a mode change so counts begin from a known point.
  task kick;
    @(posedge clk_sys);
    restart <= 1'b1;
    @(posedge clk_sys);
    restart <= 1'b0;
  endtask

  task test_done;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Clock at 200 MHz.
  initial forever #2.5 clk_sys = ~clk_sys;

  // Watchdog: the sequence needs well under a tenth of this span.
  initial
  begin
    #20000;
    err_total++;
    test_done;
  end

  // Main sequence.
  initial
  begin
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'b1;
    #1;
    `CHK(pos_ref_onehot_q, 4'h1)
    rd(4'h0, `ADCRB_RESET);
    conv(4'h7, 5'h00, 1'b1);
    for (k = 0; k < 4; k++)
    begin
      wr(4'h0, {k[1:0], k[0], 13'h0000});
      `CHK(pos_ref_onehot_q, 4'h1 << k)
      `CHK(neg_ref_ext_q, k[0])
    end
    wr(4'h0, 16'hffff);
    `CHK(offset_cal_mode_q, 1'b1)
    rd(4'h0, `ADCRB_WR_MASK);
    wr(4'h5, 16'h1234);
    rd(4'h5, 16'h0000);
    rd(4'h0, `ADCRB_WR_MASK);
    wr(4'h0, 16'h0008);
    `CHK(offset_cal_mode_q, 1'b0)
    kick;
    for (k = 0; k < 6; k++)
      conv(4'h0, k % 3, k % 3 == 2);
    wr(4'h0, 16'h0006);
    kick;
    conv(4'h0, 5'h00, 1'b0);
    conv(4'h0, 5'h01, 1'b1);
    rd(4'h0, 16'h0086);
    conv(4'h0, 5'h10, 1'b0);
    conv(4'h0, 5'h11, 1'b1);
    wr(4'h0, 16'h0802);
    kick;
    conv(4'h9, 5'h09, 1'b1);
    conv(4'h3, 5'h03, 1'b1);
    rd(4'h0, 16'h0802);
    wr(4'h0, 16'h0000);
    kick;
    conv(4'h0, 5'h00, 1'b1);
    `CHK(mux_chan_q, 4'h5)
    wr(4'h0, 16'h0400);
    kick;
    @(posedge clk_sys);
    #1;
    `CHK(mux_chan_q, 4'h0)
    conv(4'h0, 5'h00, 1'b1);
    `CHK(mux_chan_q, 4'h1)
    wr(4'h0, 16'h0001);
    kick;
    @(posedge clk_sys);
    #1;
    `CHK(mux_use_b_q, 1'b0)
    conv(4'h0, 5'h00, 1'b1);
    `CHK(mux_use_b_q, 1'b1)
    rd(4'h1, 16'h0340);
    // With the enable low a write must not land and outputs must hold.
    @(posedge clk_sys);
    ce <= 1'b0;
    wr(4'h0, 16'h2000);
    `CHK(neg_ref_ext_q, 1'b0)
    `CHK(mux_use_b_q, 1'b1)
    test_done;
  end
endmodule

bind adcrb_top adcrb_properties #(.AW(AW)) i_props (.clk_sys, .rst_n, .ce, .reg_addr,
  .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_q, .conv_done, .conv_chan, .pos_ref_onehot_q,
  .neg_ref_ext_q, .mux_use_b_q, .buf_addr_q, .buf_wr_q, .irq_q);
